// ==== logic/amp_seq_pkg.sv ====
// package: timing constants, states and carrier structs for the amplifier sequencer
// Functional notes
// - enable low forces shutdown, outputs grounded
// - enable high reaches normal after 80 ms
// - power-on starts in shutdown state
// - mute low enables both output stages
// - mute high disables stages, grounds outputs
// - enable or mute change ramps volume; enable low here drops volume to silent at once
// - shutdown entry ramps both outputs together
// - stay inactive until rising threshold seen
// - falling threshold forces immediate shutdown
// - over-temperature forces thermal shutdown, grounded
// - resume only after 20 degree hysteresis
// - short detected puts stage high impedance
// - persistent short: shutdown for 40 ms
// - after recovery, restart and recheck fault
// - fault gone after retry resumes normally
package amp_seq_pkg;
   localparam int unsigned CLK_HZ         = 40_000_000;  // sys_clk rate
   localparam int unsigned SETTLE_MS      = 40;          // shutdown_settle_time
   localparam int unsigned STARTUP_MS     = 80;          // startup_delay
   localparam int unsigned RECOVERY_MS    = 40;          // fault_recovery_time
   localparam int unsigned SETTLE_CYC     = SETTLE_MS * (CLK_HZ / 1000);
   localparam int unsigned STARTUP_CYC    = STARTUP_MS * (CLK_HZ / 1000);
   localparam int unsigned RECOVERY_CYC   = RECOVERY_MS * (CLK_HZ / 1000);
   localparam int unsigned QUAL_CYC       = 4000;        // short qualification default
   localparam int unsigned VOL_W          = 8;           // volume word width
   localparam int unsigned FADE_STEP_CYC  = 400;         // cycles per fade step
   localparam int unsigned CNT_W          = 32;          // delay counter width
   localparam logic [7:0]  VOL_MAX        = 8'hFF;       // full volume
   localparam logic [7:0]  VOL_MIN        = 8'h00;       // silent

   // sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_OFF     = 5'b00001,  // shutdown, waiting for enable
      ST_START   = 5'b00010,  // startup interval running
      ST_RUN     = 5'b00100,  // normal operation
      ST_HIZ     = 5'b01000,  // short seen, stage tristated, qualifying
      ST_RECOVER = 5'b10000   // hiccup shutdown
   } seq_state_t;

   // comparator flags from the analog side
   typedef struct packed {
      logic supply_rising_threshold;   // supply above rising trip
      logic supply_falling_threshold;  // supply below falling trip
      logic over_temp;                 // die above trip
      logic temp_cleared;              // die below trip minus hysteresis
      logic short_detect;              // output short present
   } analog_flags_t;

   // controls to the output stage
   typedef struct packed {
      logic             bias_on;       // analog bias enabled
      logic             stage_on;      // output stage switching
      logic             stage_hiz;     // output stage high impedance
      logic             pulldown_on;   // 2.5k pulldowns to ground
      logic             fast_discharge;// quick joint ramp to ground
      logic [VOL_W-1:0] volume;        // fade volume
   } stage_ctrl_t;
endpackage : amp_seq_pkg

// ==== logic/amp_fade_ramp.sv ====
// volume fade ramp toward a target level
`timescale 1ns/1ps
module amp_fade_ramp
   import amp_seq_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire logic             clk_en,
   input  wire logic             fade_up,     // 1 = ramp in, 0 = ramp out
   input  wire logic             snap_zero,   // force silent at once
   output logic      [VOL_W-1:0] volume,
   output logic                  at_zero
);
   logic [VOL_W-1:0] vol_q, vol_d;     // current volume
   logic [15:0]      tick_q, tick_d;   // step prescaler

   // next volume: one step per prescaler wrap
   always_comb begin
      vol_d  = vol_q;
      tick_d = tick_q;
      if (snap_zero) begin
         vol_d  = VOL_MIN;
         tick_d = '0;
      end else if (tick_q == 16'(FADE_STEP_CYC - 1)) begin
         tick_d = '0;
         if (fade_up && vol_q != VOL_MAX) begin    // ramp
            vol_d = vol_q + 8'h01;
         end else if (!fade_up && vol_q != VOL_MIN) begin  // ramp out
            vol_d = vol_q - 8'h01;
         end
      end else begin
         tick_d = tick_q + 16'h0001;
      end
   end

   // registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         vol_q  <= VOL_MIN;
         tick_q <= '0;
      end else if (clk_en) begin
         vol_q  <= vol_d;
         tick_q <= tick_d;
      end
   end

   assign volume  = vol_q;
   assign at_zero = (vol_q == VOL_MIN);

   fade_bound_a: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && !snap_zero && vol_q != VOL_MIN && vol_q != VOL_MAX
      |=> (vol_q == $past(vol_q)) || (vol_q == $past(vol_q) + 8'h01)
          || (vol_q == $past(vol_q) - 8'h01))
      else $error("fade moved by more than one step");
endmodule : amp_fade_ramp

// ==== logic/amp_power_protection_sequencer.sv ====
// shutdown, startup, mute, fade and protection sequencer of the amplifier
`timescale 1ns/1ps
module amp_power_protection_sequencer
   import amp_seq_pkg::*;
#(
   parameter int unsigned STARTUP_CYCLES  = STARTUP_CYC,   // startup interval
   parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYC,  // hiccup off time
   parameter int unsigned QUAL_CYCLES     = QUAL_CYC       // short qualification
)(
   input  wire logic          sys_clk,
   input  wire logic          srst,         // power-on reset
   input  wire logic          clk_en,
   input  wire logic          enable_pin,   // asynchronous host enable
   input  wire logic          mute_pin,     // asynchronous host mute
   input  wire analog_flags_t flags_raw,    // asynchronous comparator flags
   output stage_ctrl_t        stage,
   output logic               in_shutdown,
   output logic               thermal_shutdown,
   output logic               undervoltage_lockout,
   output logic               overcurrent_protection
);
   // two-stage synchronisers for every off-domain input
   logic [6:0] sync1_q, sync2_q;
   logic       en_s, mute_s;
   analog_flags_t fl;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (clk_en) begin
         sync1_q <= {enable_pin, mute_pin, flags_raw};
         sync2_q <= sync1_q;
      end
   end
   assign en_s   = sync2_q[6];
   assign mute_s = sync2_q[5];
   assign fl     = sync2_q[4:0];

   // protection latches: lockout until rising trip, thermal with hysteresis
   logic uv_q, uv_d;     // undervoltage lockout active
   logic ot_q, ot_d;     // thermal shutdown active

   always_comb begin
      uv_d = uv_q;
      if (fl.supply_falling_threshold) begin
         uv_d = 1'b1;
      end else if (fl.supply_rising_threshold) begin
         uv_d = 1'b0;
      end
      ot_d = ot_q;
      if (fl.over_temp) begin
         ot_d = 1'b1;
      end else if (fl.temp_cleared) begin
         ot_d = 1'b0;
      end
   end

   // lockout starts set so nothing runs before the supply is proven good
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         uv_q <= 1'b1;
         ot_q <= 1'b0;
      end else if (clk_en) begin
         uv_q <= uv_d;
         ot_q <= ot_d;
      end
   end

   // any of these removes bias; checked ahead of the state machine
   logic force_off;
   assign force_off = !en_s || uv_q || ot_q;

   // main sequencer
   seq_state_t         st_q, st_d;
   logic [CNT_W-1:0]   cnt_q, cnt_d;             // shared delay counter

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      if (force_off) begin
         st_d  = ST_OFF;
         cnt_d = '0;
      end else begin
         unique case (st_q)
            ST_OFF: begin
               st_d  = ST_START;
               cnt_d = '0;
            end
            ST_START: begin
               if (cnt_q >= CNT_W'(STARTUP_CYCLES - 1)) begin
                  st_d  = ST_RUN;
                  cnt_d = '0;
               end else begin
                  cnt_d = cnt_q + 32'h0000_0001;
               end
            end
            ST_RUN: begin
               if (fl.short_detect) begin
                  st_d  = ST_HIZ;
                  cnt_d = '0;
               end
            end
            ST_HIZ: begin
               if (!fl.short_detect) begin
                  st_d  = ST_RUN;
                  cnt_d = '0;
               end else if (cnt_q >= CNT_W'(QUAL_CYCLES - 1)) begin
                  st_d  = ST_RECOVER;
                  cnt_d = '0;
               end else begin
                  cnt_d = cnt_q + 32'h0000_0001;
               end
            end
            ST_RECOVER: begin
               if (cnt_q >= CNT_W'(RECOVERY_CYCLES - 1)) begin
                  st_d  = ST_START;
                  cnt_d = '0;
               end else begin
                  cnt_d = cnt_q + 32'h0000_0001;
               end
            end
            default: begin
               st_d  = ST_OFF;
               cnt_d = '0;
            end
         endcase
      end
   end

   // state registers; reset puts the part in shutdown
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q  <= ST_OFF;
         cnt_q <= '0;
      end else if (clk_en) begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // fade engine: up only in run with mute low, so fade waits for startup
   logic             fade_up;
   logic [VOL_W-1:0] vol;
   logic             vol_zero;
   assign fade_up = (st_q == ST_RUN) && !mute_s;

   amp_fade_ramp u_fade (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .clk_en    (clk_en),
      .fade_up   (fade_up),
      .snap_zero (st_q != ST_RUN),   // shutdown paths drop volume at once
      .volume    (vol),
      .at_zero   (vol_zero)
   );

   // output stage controls, registered
   stage_ctrl_t stage_q, stage_d;

   always_comb begin
      stage_d        = '0;
      stage_d.volume = vol;
      unique case (st_q)
         ST_OFF, ST_RECOVER: begin
            stage_d.pulldown_on    = 1'b1;
            stage_d.fast_discharge = 1'b1;
         end
         ST_START: begin
            stage_d.bias_on     = 1'b1;
            stage_d.pulldown_on = 1'b1;
         end
         ST_RUN: begin
            stage_d.bias_on = 1'b1;
            // mute only gates after fade-out reaches silence
            if (mute_s && vol_zero) begin
               stage_d.pulldown_on = 1'b1;
            end else begin
               stage_d.stage_on = 1'b1;
            end
         end
         ST_HIZ: begin
            stage_d.bias_on   = 1'b1;
            stage_d.stage_hiz = 1'b1;
         end
         default: begin
            stage_d.pulldown_on = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stage_q <= '{bias_on: 1'b0, stage_on: 1'b0, stage_hiz: 1'b0,
                      pulldown_on: 1'b1, fast_discharge: 1'b1, volume: VOL_MIN};
      end else if (clk_en) begin
         stage_q <= stage_d;
      end
   end

   assign stage                  = stage_q;
   assign in_shutdown            = (st_q == ST_OFF) || (st_q == ST_RECOVER);
   assign thermal_shutdown       = ot_q;
   assign undervoltage_lockout   = uv_q;
   assign overcurrent_protection = (st_q == ST_HIZ) || (st_q == ST_RECOVER);

   // assertions
   off_on_drop_a: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && force_off |=> st_q == ST_OFF)
      else $error("shutdown cause did not force off state");

   start_run_a: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && st_q == ST_START && !force_off && cnt_q == CNT_W'(STARTUP_CYCLES - 1)
      |=> st_q == ST_RUN)
      else $error("startup did not finish on time");

   uv_trip_a: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && fl.supply_falling_threshold |=> uv_q ##1 (st_q == ST_OFF || !$past(clk_en)))
      else $error("undervoltage did not shut down");

   ot_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      ot_q && !fl.temp_cleared |=> ot_q)
      else $error("thermal shutdown released early");

   short_hiz_a: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && st_q == ST_RUN && fl.short_detect && !force_off
      |=> st_q == ST_HIZ ##1 (stage.stage_hiz || !$past(clk_en) || st_q != ST_HIZ))
      else $error("short did not tristate stage");

   qual_trip_a: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && st_q == ST_HIZ && fl.short_detect && !force_off
      && cnt_q == CNT_W'(QUAL_CYCLES - 1) |=> st_q == ST_RECOVER)
      else $error("qualified short did not enter recovery");

   retry_a: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && st_q == ST_RECOVER && !force_off
      && cnt_q == CNT_W'(RECOVERY_CYCLES - 1) |=> st_q == ST_START)
      else $error("recovery did not restart");

   mute_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && st_q == ST_RUN && mute_s && vol_zero
      |=> !stage.stage_on && stage.pulldown_on)
      else $error("mute did not disable stage");

   fade_wait_a: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && st_q != ST_RUN |=> vol_zero)
      else $error("fade began before startup finished");
endmodule : amp_power_protection_sequencer

// ==== testbench/amp_host_model.sv ====
// host controller model that drives the enable and mute pins
`timescale 1ns/1ps
module amp_host_model #(
   parameter int unsigned SETTLE_CYCLES = 10  // scaled minimum enable-low time
)(
   input  wire logic sys_clk,
   output logic      enable_pin,
   output logic      mute_pin
);
   int unsigned low_cnt = 0;  // cycles enable has stayed low

   // pins start low so the part sits in shutdown until told otherwise
   initial begin
      enable_pin = 1'b0;
      mute_pin   = 1'b0;
   end

   // count the low time so a rise is never early
   always @(posedge sys_clk) begin
      low_cnt <= enable_pin ? 0 : low_cnt + 1;
   end

   // a rise waits out the settle time; pins change at the falling edge
   task automatic set_enable(input logic v);
      if (v) begin
         while (low_cnt < SETTLE_CYCLES) @(negedge sys_clk);
      end
      @(negedge sys_clk);
      enable_pin = v;
   endtask : set_enable

   // mute is a plain level, no spacing needed
   task automatic set_mute(input logic v);
      @(negedge sys_clk);
      mute_pin = v;
   endtask : set_mute
endmodule : amp_host_model

// ==== testbench/amp_power_protection_sequencer_tb.sv ====
// self-checking bench of the amplifier sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module amp_power_protection_sequencer_tb;
   import amp_seq_pkg::*;
   localparam int unsigned ST = 20;  // shortened startup interval
   localparam int unsigned RC = 10;  // shortened hiccup off time
   localparam int unsigned QC = 20;  // shortened short qualification
   logic          sys_clk = 1'b0;    // 40 MHz clock
   logic          srst    = 1'b1;    // power-on reset
   logic          clk_en  = 1'b1;    // clock enable, dropped to test freezing
   logic          enable_pin;        // from host model
   logic          mute_pin;          // from host model
   analog_flags_t flags   = '0;      // comparator flags, supply absent
   stage_ctrl_t   stage;             // output stage controls
   logic          in_shutdown;
   logic          thermal_shutdown;
   logic          undervoltage_lockout;
   logic          overcurrent_protection;
   int            miscompares = 0;
   int            tests_run   = 0;

   // short counts keep the run small; startup, hiccup and qualification delays are parameters, the fade step is not
   amp_power_protection_sequencer #(
      .STARTUP_CYCLES(ST), .RECOVERY_CYCLES(RC), .QUAL_CYCLES(QC)
   ) dut (
      .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .enable_pin(enable_pin),
      .mute_pin(mute_pin), .flags_raw(flags), .stage(stage), .in_shutdown(in_shutdown),
      .thermal_shutdown(thermal_shutdown), .undervoltage_lockout(undervoltage_lockout),
      .overcurrent_protection(overcurrent_protection)
   );

   // host keeps its default scaled settle count
   amp_host_model host (
      .sys_clk(sys_clk), .enable_pin(enable_pin), .mute_pin(mute_pin)
   );

   // free-running clock, 25 ns period
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // idle at falling edges, where every output has settled
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wait_cyc

   // reset state, then enable without supply stays inactive
   task automatic t_power_on();
      `CHK("in_shutdown", 1'b1, in_shutdown)
      `CHK("pulldown", 1'b1, stage.pulldown_on)
      `CHK("undervoltage_lockout", 1'b1, undervoltage_lockout)
      host.set_enable(1'b1);
      wait_cyc(40);
      `CHK("no_bias", 1'b0, stage.bias_on)
      host.set_enable(1'b0);
      flags.supply_rising_threshold = 1'b1;
      wait_cyc(10);
      `CHK("undervoltage_lockout_off", 1'b0, undervoltage_lockout)
      $display("test power_on done");
   endtask : t_power_on

   // enable after supply is good: startup interval, then fade in
   task automatic t_startup();
      host.set_enable(1'b1);
      wait_cyc(ST - 2);
      `CHK("early_run", 1'b0, stage.stage_on)
      `CHK("early_vol", VOL_MIN, stage.volume)
      wait_cyc(10);
      `CHK("run", 1'b1, stage.stage_on)
      `CHK("out_shut", 1'b0, in_shutdown)
      wait_cyc(3 * FADE_STEP_CYC + 10);
      `CHK("fade_in", 1'b1, stage.volume > VOL_MIN)
      $display("test startup done");
   endtask : t_startup

   // mute fades out before the stage stops, unmute restarts it
   task automatic t_mute();
      host.set_mute(1'b1);
      wait_cyc(30);
      `CHK("fading", 1'b1, stage.stage_on)
      wait_cyc(6 * FADE_STEP_CYC);
      `CHK("muted", 1'b0, stage.stage_on)
      `CHK("mute_pd", 1'b1, stage.pulldown_on)
      host.set_mute(1'b0);
      wait_cyc(10);
      `CHK("unmuted", 1'b1, stage.stage_on)
      $display("test mute done");
   endtask : t_mute

   // persistent short: hi-z, hiccup off, retry, then recovery
   task automatic t_short();
      @(negedge sys_clk) flags.short_detect = 1'b1;
      wait_cyc(6);
      `CHK("hiz", 1'b1, stage.stage_hiz)
      `CHK("ocp", 1'b1, overcurrent_protection)
      wait_cyc(QC + 3);
      `CHK("hiccup", 1'b1, in_shutdown)
      wait_cyc(RC + 5);
      `CHK("retry", 1'b1, stage.bias_on)
      `CHK("retry_on", 1'b0, in_shutdown)
      wait_cyc(ST + 10);
      `CHK("again", 1'b1, overcurrent_protection)
      flags.short_detect = 1'b0;
      wait_cyc(QC + RC + ST + 20);
      `CHK("restored", 1'b1, stage.stage_on)
      `CHK("ocp_off", 1'b0, overcurrent_protection)
      $display("test short done");
   endtask : t_short

   // thermal trip holds until the hysteresis flag clears it
   task automatic t_thermal();
      @(negedge sys_clk) flags.over_temp = 1'b1;
      wait_cyc(8);
      `CHK("thermal_shutdown", 1'b1, thermal_shutdown)
      `CHK("ot_pd", 1'b1, stage.pulldown_on)
      `CHK("ot_off", 1'b0, stage.stage_on)
      flags.over_temp = 1'b0;
      wait_cyc(40);
      `CHK("hyst", 1'b1, thermal_shutdown)
      flags.temp_cleared = 1'b1;
      wait_cyc(ST + 20);
      `CHK("ot_clr", 1'b0, thermal_shutdown)
      `CHK("ot_run", 1'b1, stage.stage_on)
      flags.temp_cleared = 1'b0;
      $display("test thermal done");
   endtask : t_thermal

   // frozen clock enable holds all state; then a mid-run reset
   task automatic t_freeze();
      @(negedge sys_clk) clk_en = 1'b0;
      host.set_enable(1'b0);
      wait_cyc(8);
      `CHK("frz_run", 1'b1, stage.stage_on)
      `CHK("frz_shut", 1'b0, in_shutdown)
      clk_en = 1'b1;
      wait_cyc(8);
      `CHK("thaw_off", 1'b1, in_shutdown)
      host.set_enable(1'b1);
      wait_cyc(ST + 10);
      `CHK("pre_rst", 1'b1, stage.stage_on)
      srst = 1'b1;
      wait_cyc(2);
      srst = 1'b0;
      `CHK("rst_shut", 1'b1, in_shutdown)
      `CHK("rst_undervoltage_lockout", 1'b1, undervoltage_lockout)
      `CHK("rst_stage", 1'b0, stage.stage_on)
      wait_cyc(ST + 10);
      `CHK("rst_run", 1'b1, stage.stage_on)
      $display("test freeze_reset done");
   endtask : t_freeze

   // supply collapse, then enable low, both ramp outputs to ground
   task automatic t_shutdown();
      @(negedge sys_clk) flags = 5'h08;
      wait_cyc(8);
      `CHK("uv_lock", 1'b1, undervoltage_lockout)
      `CHK("uv_shut", 1'b1, in_shutdown)
      `CHK("uv_dis", 1'b1, stage.fast_discharge)
      flags = 5'h10;
      wait_cyc(ST + 30);
      host.set_enable(1'b0);
      wait_cyc(8);
      `CHK("en_shut", 1'b1, in_shutdown)
      `CHK("en_bias", 1'b0, stage.bias_on)
      `CHK("en_pd", 1'b1, stage.pulldown_on)
      `CHK("en_dis", 1'b1, stage.fast_discharge)
      $display("test shutdown done");
   endtask : t_shutdown

   // single place where the run ends
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   // main sequence: reset for 16 cycles, then each scenario in turn
   initial begin
      wait_cyc(16);
      srst = 1'b0;
      wait_cyc(2);
      t_power_on();
      t_startup();
      t_mute();
      t_short();
      t_thermal();
      t_freeze();
      t_shutdown();
      end_of_test();
   end

   // watchdog, several times the expected run length
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      end_of_test();
   end
endmodule : amp_power_protection_sequencer_tb
